// ---- bench/ifp_core_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// CPU core and peripheral sources
// ----------------------------------------
module ifp_core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Controller side
  input wire ifp_pkg::ifp_req_t cpu_req,
  output logic take_ack,
  output logic [8:0] periph_event,
  // Bench control
  input wire logic ack_slow,
  input wire logic [8:0] fire
);
  logic [1:0] wait_cnt;
  logic taken;

  // Each source request on fire is registered onto periph_event one cycle later
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      periph_event <= 9'h000;
    end else begin
      periph_event <= fire;
    end
  end

  // Core takes a presented request once, at once or after a delay
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      take_ack <= 1'b0;
      wait_cnt <= 2'h0;
      taken <= 1'b0;
    end else begin
      take_ack <= 1'b0;
      if (!cpu_req.valid) begin
        taken <= 1'b0;
        wait_cnt <= 2'h0;
      end else if (!taken) begin
        if (!ack_slow || wait_cnt == 2'h3) begin
          take_ack <= 1'b1;
          taken <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule : ifp_core_model

// ---- bench/interrupt_flag_priority_ctrl_test.sv ----
`timescale 1ns/1ns
`include "ifp_defines.svh"
module interrupt_flag_priority_ctrl_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [2:0] ext_pin = 3'h0;
  logic [8:0] periph_event;
  logic timed_disable_active = 1'b0;
  logic priority_msb_set = 1'b0;
  logic [3:0] trap_level = 4'h0;
  logic take_ack;
  ifp_pkg::ifp_req_t cpu_req;
  logic [3:0] cpu_level;
  logic alternate_vector_select;
  logic irq;
  logic ack_slow = 1'b0;
  logic [8:0] fire = 9'h000;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pos [9] = '{1, 2, 3, 7, 9, 10, 11, 12, 13};

  ifp_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .periph_event(periph_event), .timed_disable_active(timed_disable_active),
    .priority_msb_set(priority_msb_set), .trap_level(trap_level), .take_ack(take_ack),
    .cpu_req(cpu_req), .cpu_level(cpu_level), .alternate_vector_select(alternate_vector_select),
    .irq(irq));

  ifp_core_model core (.sys_clk(sys_clk), .rstn(rstn), .cpu_req(cpu_req), .take_ack(take_ack),
    .periph_event(periph_event), .ack_slow(ack_slow), .fire(fire));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask : rchk

  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic req_chk(input logic [15:0] exp);
    settle();
    chk("cpu_req", {7'h00, cpu_req}, exp);
  endtask : req_chk

  task automatic pin(input int p, input logic v, input logic flag);
    @(posedge sys_clk);
    ext_pin[p] <= v;
    settle();
    if (p == 0) rchk(`IFP_ADDR_FLAGS_ZERO, {15'h0, flag});
    else rchk(`IFP_ADDR_FLAGS_ONE, 16'(flag) << (p - 1));
    wr(`IFP_ADDR_FLAGS_ZERO, 16'h0000);
    wr(`IFP_ADDR_FLAGS_ONE, 16'h0000);
  endtask : pin

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    rchk(`IFP_ADDR_PRIO_FIVE, 16'h0004);
    rchk(`IFP_ADDR_PRIO_SEVEN, 16'h0040);
    rchk(`IFP_ADDR_PRIO_BASE + 8'h06, 16'h0004);
    rchk(8'h1e, 16'h0000);
    wr(`IFP_ADDR_PRIO_FIVE, 16'hffff);
    rchk(`IFP_ADDR_PRIO_FIVE, 16'h0007);
    wr(`IFP_ADDR_PRIO_SEVEN, 16'hffff);
    rchk(`IFP_ADDR_PRIO_SEVEN, 16'h0070);
    for (int p = 0; p < 3; p++) begin
      wr(`IFP_ADDR_INT_CTRL_TWO, 16'(1) << p);
      pin(p, 1'b1, 1'b0);
      pin(p, 1'b0, 1'b1);
      wr(`IFP_ADDR_INT_CTRL_TWO, 16'h0000);
      pin(p, 1'b1, 1'b1);
      pin(p, 1'b0, 1'b0);
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      fire <= 9'(1) << i;
      @(posedge sys_clk);
      fire <= 9'h000;
      settle();
      rchk(`IFP_ADDR_FLAGS_ZERO, 16'(1) << pos[i]);
      wr(`IFP_ADDR_FLAGS_ZERO, 16'h0000);
    end
    wr(`IFP_ADDR_FLAGS_ZERO, 16'h0088);
    wr(`IFP_ADDR_ENABLE, 16'h0008);
    req_chk(16'h0143);
    ack_slow <= 1'b1;
    wr(`IFP_ADDR_PRIO_BASE + 8'h08, 16'h0005);
    wr(`IFP_ADDR_ENABLE, 16'h0018);
    req_chk(16'h0154);
    wr(`IFP_ADDR_STATUS_WORD, 16'h00a0);
    settle();
    chk("req valid", {15'h0, cpu_req.valid}, 16'h0000);
    wr(`IFP_ADDR_STATUS_WORD, 16'h0060);
    req_chk(16'h0154);
    wr(`IFP_ADDR_PRIO_BASE + 8'h08, 16'h0000);
    req_chk(16'h0143);
    wr(`IFP_ADDR_STATUS_WORD, 16'h0000);
    wr(`IFP_ADDR_PRIO_BASE + 8'h06, 16'h0006);
    timed_disable_active <= 1'b1;
    settle();
    chk("req valid", {15'h0, cpu_req.valid}, 16'h0000);
    rchk(`IFP_ADDR_INT_CTRL_TWO, 16'h4000);
    wr(`IFP_ADDR_PRIO_BASE + 8'h06, 16'h0007);
    req_chk(16'h0173);
    @(posedge sys_clk);
    timed_disable_active <= 1'b0;
    wr(`IFP_ADDR_STATUS_WORD, 16'h00e0);
    settle();
    chk("req valid", {15'h0, cpu_req.valid}, 16'h0000);
    @(posedge sys_clk);
    trap_level <= 4'h9;
    req_chk(16'h019f);
    @(posedge sys_clk);
    trap_level <= 4'h0;
    @(posedge sys_clk);
    priority_msb_set <= 1'b1;
    @(posedge sys_clk);
    priority_msb_set <= 1'b0;
    settle();
    chk("cpu_level", {12'h0, cpu_level}, 16'h000f);
    rchk(`IFP_ADDR_CORE_CTRL, 16'h0008);
    wr(`IFP_ADDR_CORE_CTRL, 16'h0000);
    wr(`IFP_ADDR_STATUS_WORD, 16'h0040);
    settle();
    chk("cpu_level", {12'h0, cpu_level}, 16'h0002);
    wr(`IFP_ADDR_INT_CTRL_TWO, 16'h8000);
    settle();
    chk("alt vector", {15'h0, alternate_vector_select}, 16'h0001);
    rchk(`IFP_ADDR_EVT_STATUS, 16'h0003);
    wr(`IFP_ADDR_EVT_MASK, 16'h0001);
    settle();
    chk("irq", {15'h0, irq}, 16'h0001);
    wr(`IFP_ADDR_EVT_MASK, 16'h0000);
    settle();
    chk("irq", {15'h0, irq}, 16'h0000);
    wr(`IFP_ADDR_FLAGS_ZERO, 16'h0000);
    req_chk(16'h0000);
    wr(`IFP_ADDR_EVT_STATUS, 16'h0003);
    wr(`IFP_ADDR_EVT_MASK, 16'h0003);
    settle();
    rchk(`IFP_ADDR_EVT_STATUS, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    test_done();
  end
endmodule : interrupt_flag_priority_ctrl_test

// ---- include/ifp_defines.svh ----
`ifndef IFP_DEFINES_SVH
`define IFP_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IFP_ADDR_CORE_CTRL 8'h00
`define IFP_ADDR_STATUS_WORD 8'h02
`define IFP_ADDR_INT_CTRL_TWO 8'h04
`define IFP_ADDR_FLAGS_ZERO 8'h06
`define IFP_ADDR_FLAGS_ONE 8'h08
`define IFP_ADDR_PRIO_FIVE 8'h0a
`define IFP_ADDR_PRIO_SEVEN 8'h0c
`define IFP_ADDR_ENABLE 8'h10
`define IFP_ADDR_EVT_STATUS 8'h12
`define IFP_ADDR_EVT_MASK 8'h14
`define IFP_ADDR_PRIO_BASE 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IFP_CC_MSB 3
`define IFP_SW_LEVEL_LSB 5
`define IFP_IC2_ALT 15
`define IFP_IC2_TIMED_DISABLE_STATUS 14
`define IFP_FLG_EXT0 0
`define IFP_FLG_IC 1
`define IFP_FLG_OC 2
`define IFP_FLG_T1 3
`define IFP_FLG_T2 7
`define IFP_FLG_SPIE 9
`define IFP_FLG_SPI 10
`define IFP_FLG_RX 11
`define IFP_FLG_TX 12
`define IFP_FLG_ADC 13
`define IFP_P5_LSB 0
`define IFP_P7_LSB 4
`define IFP_EVT_FLAG 0
`define IFP_EVT_TAKEN 1

// ----------------------------------------
// Sources, levels and reset values
// ----------------------------------------
`define IFP_NUM_SRC 12
`define IFP_NUM_OWN_PRIO 10
`define IFP_SRC_EXT1 10
`define IFP_SRC_EXT2 11
`define IFP_SRC_TRAP 4'hf
`define IFP_PRIO_RESET 3'h4
`define IFP_PRIO_OFF 3'h0
`define IFP_PRIO_TOP 3'h7
`define IFP_TRAP_MIN 4'h8

`endif

// ---- include/ifp_pkg.sv ----
package ifp_pkg;

  // Request presented to the CPU core
  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [3:0] source;
  } ifp_req_t;

  // Per-source 3-bit priority code
  typedef logic [2:0] ifp_prio_t;

endpackage : ifp_pkg

// ---- src/ifp_arbiter.sv ----
`timescale 1ns/1ns
`include "ifp_defines.svh"
// ----------------------------------------
// Priority resolution against the CPU level
// ----------------------------------------
module ifp_arbiter #(
  parameter int NUM_SRC = 12
) (
  // Source state
  input wire logic [NUM_SRC-1:0] pending,
  input wire ifp_pkg::ifp_prio_t prio [NUM_SRC],
  // Core state
  input wire logic timed_disable,
  input wire logic [3:0] cpu_level,
  input wire logic [3:0] trap_level,
  // Winning request
  output ifp_pkg::ifp_req_t winner
);

  logic [NUM_SRC-1:0] eligible;

  genvar g;
  for (g = 0; g < NUM_SRC; g++) begin : g_elig
    assign eligible[g] = pending[g] && (prio[g] != `IFP_PRIO_OFF)
                         && (!timed_disable || prio[g] == `IFP_PRIO_TOP);
  end

  always_comb begin
    logic [2:0] best;
    logic [3:0] best_src;
    best = `IFP_PRIO_OFF;
    best_src = 4'h0;
    // Lowest index wins a tie
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && prio[i] >= best) begin
        best = prio[i];
        best_src = 4'(i);
      end
    end
    winner = '0;
    if (trap_level >= `IFP_TRAP_MIN) begin
      // Traps ignore the CPU level entirely
      winner.valid = 1'b1;
      winner.level = trap_level;
      winner.source = `IFP_SRC_TRAP;
    end else if (best != `IFP_PRIO_OFF && {1'b0, best} > cpu_level) begin
      winner.valid = 1'b1;
      winner.level = {1'b0, best};
      winner.source = best_src;
    end
  end

endmodule : ifp_arbiter

// ---- src/ifp_ctrl.sv ----
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "ifp_defines.svh"
module ifp_ctrl #(
  parameter int NUM_SRC = `IFP_NUM_SRC,
  parameter int NUM_EXT = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Interrupt sources: ext pins 0-2, ic, oc, t1, t2, spi err, spi, rx, tx, adc
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic [8:0] periph_event,
  // CPU core
  input wire logic timed_disable_active,
  input wire logic priority_msb_set,
  input wire logic [3:0] trap_level,
  input wire logic take_ack,
  output ifp_pkg::ifp_req_t cpu_req,
  output logic [3:0] cpu_level,
  output logic alternate_vector_select,
  // Event interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NUM_SRC-1:0] flag;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_EXT-1:0] edge_sel;
  logic [NUM_EXT-1:0] edge_pulse;
  ifp_pkg::ifp_prio_t prio [NUM_SRC];
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic [1:0] evt_set;
  logic timed_disable_status;
  ifp_pkg::ifp_req_t next_req;
  logic [15:0] next_rdata;
  logic [7:0] prio_off;

  // Flag bit position of each source in its flag register
  localparam int FLAG_POS [NUM_SRC] = '{`IFP_FLG_EXT0, `IFP_FLG_IC, `IFP_FLG_OC, `IFP_FLG_T1,
    `IFP_FLG_T2, `IFP_FLG_SPIE, `IFP_FLG_SPI, `IFP_FLG_RX, `IFP_FLG_TX, `IFP_FLG_ADC, 0, 1};

  // ----------------------------------------
  // External pin edges
  // ----------------------------------------
  ifp_edge_detect #(.NUM_PINS(NUM_EXT)) u_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(ext_pin),
    .falling_sel(edge_sel),
    .edge_pulse(edge_pulse)
  );

  assign set_vec = {edge_pulse[2], edge_pulse[1], periph_event, edge_pulse[0]};

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  genvar g;
  for (g = 0; g < NUM_SRC; g++) begin : g_flag
    localparam logic [7:0] FLG_ADDR = (g < `IFP_NUM_OWN_PRIO) ? `IFP_ADDR_FLAGS_ZERO : `IFP_ADDR_FLAGS_ONE;
    // Flag stays set until software clears it; a hardware set wins over the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        flag[g] <= 1'b0;
      end else if (set_vec[g]) begin
        flag[g] <= 1'b1;
      end else if (reg_wr && reg_addr == FLG_ADDR) begin
        flag[g] <= reg_wdata[FLAG_POS[g]];
      end
    end
  end

  // ----------------------------------------
  // Priority fields
  // ----------------------------------------
  for (g = 0; g < NUM_SRC; g++) begin : g_prio
    localparam logic [7:0] P_ADDR = (g == `IFP_SRC_EXT1) ? `IFP_ADDR_PRIO_FIVE :
                                    (g == `IFP_SRC_EXT2) ? `IFP_ADDR_PRIO_SEVEN :
                                    8'(`IFP_ADDR_PRIO_BASE + 2 * g);
    localparam int P_LSB = (g == `IFP_SRC_EXT2) ? `IFP_P7_LSB : `IFP_P5_LSB;
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        prio[g] <= `IFP_PRIO_RESET;
      end else if (reg_wr && reg_addr == P_ADDR) begin
        prio[g] <= reg_wdata[P_LSB +: 3];
      end
    end
  end

  // ----------------------------------------
  // CPU priority level
  // ----------------------------------------
  // Bit 3 is set by the core and only cleared by software
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_level[3] <= 1'b0;
    end else if (priority_msb_set) begin
      cpu_level[3] <= 1'b1;
    end else if (reg_wr && reg_addr == `IFP_ADDR_CORE_CTRL && !reg_wdata[`IFP_CC_MSB]) begin
      cpu_level[3] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_level[2:0] <= 3'h0;
    end else if (reg_wr && reg_addr == `IFP_ADDR_STATUS_WORD) begin
      cpu_level[2:0] <= reg_wdata[`IFP_SW_LEVEL_LSB +: 3];
    end
  end

  // ----------------------------------------
  // Control two, enables, timed disable
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alternate_vector_select <= 1'b0;
      edge_sel <= '0;
    end else if (reg_wr && reg_addr == `IFP_ADDR_INT_CTRL_TWO) begin
      alternate_vector_select <= reg_wdata[`IFP_IC2_ALT];
      edge_sel <= reg_wdata[NUM_EXT-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable <= '0;
    end else if (reg_wr && reg_addr == `IFP_ADDR_ENABLE) begin
      enable <= reg_wdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timed_disable_status <= 1'b0;
    end else begin
      timed_disable_status <= timed_disable_active;
    end
  end

  // ----------------------------------------
  // Arbitration toward the core
  // ----------------------------------------
  ifp_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
    .pending(flag & enable),
    .prio(prio),
    .timed_disable(timed_disable_status),
    .cpu_level(cpu_level),
    .trap_level(trap_level),
    .winner(next_req)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_req <= '0;
    end else begin
      cpu_req <= next_req;
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------
  assign evt_set = {take_ack, |set_vec};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_status <= 2'h0;
    end else begin
      // Set wins over write-one-to-clear
      evt_status <= evt_set | (evt_status &
                    ~((reg_wr && reg_addr == `IFP_ADDR_EVT_STATUS) ? reg_wdata[1:0] : 2'h0));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_mask <= 2'h0;
    end else if (reg_wr && reg_addr == `IFP_ADDR_EVT_MASK) begin
      evt_mask <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  assign prio_off = reg_addr - `IFP_ADDR_PRIO_BASE;

  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      `IFP_ADDR_CORE_CTRL: next_rdata[`IFP_CC_MSB] = cpu_level[3];
      `IFP_ADDR_STATUS_WORD: next_rdata[`IFP_SW_LEVEL_LSB +: 3] = cpu_level[2:0];
      `IFP_ADDR_INT_CTRL_TWO: begin
        next_rdata[`IFP_IC2_ALT] = alternate_vector_select;
        next_rdata[`IFP_IC2_TIMED_DISABLE_STATUS] = timed_disable_status;
        next_rdata[NUM_EXT-1:0] = edge_sel;
      end
      `IFP_ADDR_FLAGS_ZERO: begin
        for (int i = 0; i < `IFP_NUM_OWN_PRIO; i++) begin
          next_rdata[FLAG_POS[i]] = flag[i];
        end
      end
      `IFP_ADDR_FLAGS_ONE: next_rdata[1:0] = flag[`IFP_SRC_EXT2:`IFP_SRC_EXT1];
      `IFP_ADDR_PRIO_FIVE: next_rdata[`IFP_P5_LSB +: 3] = prio[`IFP_SRC_EXT1];
      `IFP_ADDR_PRIO_SEVEN: next_rdata[`IFP_P7_LSB +: 3] = prio[`IFP_SRC_EXT2];
      `IFP_ADDR_ENABLE: next_rdata[NUM_SRC-1:0] = enable;
      `IFP_ADDR_EVT_STATUS: next_rdata[1:0] = evt_status;
      `IFP_ADDR_EVT_MASK: next_rdata[1:0] = evt_mask;
      default: begin
        if (!prio_off[0] && prio_off[7:1] < 7'(`IFP_NUM_OWN_PRIO)) begin
          next_rdata[2:0] = prio[prio_off[4:1]];
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_msb_set_wins: assert property (priority_msb_set |=> cpu_level[3])
    else $error("cpu priority msb not set");
  a_level_write: assert property (reg_wr && reg_addr == `IFP_ADDR_STATUS_WORD && !priority_msb_set
    |=> cpu_level[2:0] == $past(reg_wdata[7:5]))
    else $error("cpu level low field not written");
  for (g = 0; g < NUM_SRC; g++) begin : g_chk
    a_flag_set_sticky: assert property (set_vec[g] |=> flag[g])
      else $error("request flag lost its set");
  end
  a_user_level_range: assert property (cpu_req.valid && cpu_req.source != `IFP_SRC_TRAP
    |-> cpu_req.level != 4'h0 && !cpu_req.level[3])
    else $error("disabled or bad level presented");
  a_above_cpu_level: assert property (cpu_req.valid && cpu_req.source != `IFP_SRC_TRAP
    |-> cpu_req.level > $past(cpu_level))
    else $error("request not above cpu level");
  a_level7_masks: assert property ($past(cpu_level) >= 4'h7 && cpu_req.valid |-> cpu_req.level[3])
    else $error("user request passed level 7");
  a_trap_unmasked: assert property (trap_level >= 4'h8 |=> cpu_req.valid && cpu_req.level == $past(trap_level))
    else $error("trap not presented");
  a_timed_disable_status_blocks: assert property ($past(timed_disable_status) && cpu_req.valid && !cpu_req.level[3]
    |-> cpu_req.level == 4'h7)
    else $error("timed disable let low level through");
  a_unimpl_zero: assert property (reg_rd && reg_addr == `IFP_ADDR_PRIO_SEVEN
    |=> reg_rdata[15:7] == 9'h000 && reg_rdata[3:0] == 4'h0)
    else $error("unimplemented bits read nonzero");
  a_timed_disable_status_status: assert property (timed_disable_active ##1 reg_rd && reg_addr == `IFP_ADDR_INT_CTRL_TWO
    |=> reg_rdata[14])
    else $error("timed disable status not shown");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_irq_follows: assert property (irq == |($past(evt_status) & $past(evt_mask)))
    else $error("irq does not follow masked status");

  c_user_request: cover property (cpu_req.valid && cpu_req.source != `IFP_SRC_TRAP);
  c_trap_request: cover property (cpu_req.valid && cpu_req.source == `IFP_SRC_TRAP);
  c_timed_disable_status_level7: cover property (timed_disable_status && cpu_req.valid && cpu_req.level == 4'h7);
  c_set_on_clear: cover property (set_vec[3] && reg_wr && reg_addr == `IFP_ADDR_FLAGS_ZERO);

endmodule : ifp_ctrl

// ---- src/ifp_edge_detect.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Per-pin edge detector with polarity select
// ----------------------------------------
module ifp_edge_detect #(
  parameter int NUM_PINS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pins and polarity (1 = falling edge)
  input wire logic [NUM_PINS-1:0] pin,
  input wire logic [NUM_PINS-1:0] falling_sel,
  // One-cycle edge pulses
  output logic [NUM_PINS-1:0] edge_pulse
);

  logic [NUM_PINS-1:0] pin_prev;
  logic armed;

  // Armed after the first sample so reset does not fake an edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  genvar g;
  for (g = 0; g < NUM_PINS; g++) begin : g_pin
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        pin_prev[g] <= 1'b0;
      end else begin
        pin_prev[g] <= pin[g];
      end
    end
    assign edge_pulse[g] = armed & (falling_sel[g] ? (pin_prev[g] & ~pin[g]) : (~pin_prev[g] & pin[g]));
  end

endmodule : ifp_edge_detect
